// File: hdl/trim_map.svh
`ifndef TRIM_MAP_SVH
`define TRIM_MAP_SVH
// byte addresses on the register bus
`define REF_OSC_TRIM_ADDR     12'h2F8
`define TEMP_SENSE_TRIM_ADDR  12'h2F4
`define CLOCK_PROTECT_ADDR    12'h2FB
`define CLOCK_PROTECT_WADDR   12'h2FC
`define STATUS_ADDR           12'h300
`define PLL_CTRL_ADDR         12'h304
// field positions
`define TEMP_OFFSET_EN_BIT    7
`define TEMP_THRESH_LSB       0
`define TEMPCO_MSB            15
`define TEMPCO_LSB            11
`define FREQ_MSB              9
`define FREQ_LSB              0
// values
`define PROTECT_UNLOCK_KEY    8'h26
`define TEMP_SENSE_RESET      8'h00
`define REF_OSC_RESET         16'h0000
`define PROTECT_RESET         1'b0
`define TEMP_SENSE_MASK       8'h8F
`define REF_OSC_MASK          16'hFBFF
`endif

// File: hdl/trim_pkg.sv
`default_nettype none
package trim_pkg;
    typedef struct packed
    {
        logic       offset_en;
        logic [3:0] thresh_trim;
    } temp_trim_type;
    typedef struct packed
    {
        logic       tc_on;
        logic       tc_positive;
        logic [3:0] tc_mag;
        logic [9:0] freq_trim;
    } osc_trim_type;
    typedef enum logic [2:0]
    {
        LD_IDLE = 3'b001,
        LD_REQ  = 3'b010,
        LD_DONE = 3'b100
    } load_state_type;
endpackage
`default_nettype wire

// File: hdl/thresh_weight.sv
`timescale 1ns/1ps
`default_nettype none
// binary-weighted threshold raise, zero while offset disabled
module thresh_weight
(
    input  wire logic       en,
    input  wire logic [3:0] trim,
    output logic [4:0]      raise_steps
);
    assign raise_steps = en ? {1'b0, trim} : 5'h00;
endmodule
`default_nettype wire

// File: hdl/osc_temp_trim_regs.sv
// Notes on behaviour
// R1: offset enable bit 7 turns temperature offset on; clear ignores threshold trim.
// R2: threshold trim bits 3..0 binary weighted, each double the one below.
// R3: after reset release the flash trim value is loaded into oscillator trim.
// R4: oscillator trim writes only while protection clear; reads anytime.
// R5: oscillator trim write with pll select set clears lock and osc-up flags.
// R6: tempco bits 15..11; 00000 and 10000 switch compensation off; msb gives direction.
// R7: frequency trim bits 9..0 drive the reference oscillator adjustment.
// R8: writing 0x26 to protection register clears protection; other writes set it.
// R9: unimplemented bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "trim_map.svh"
module osc_temp_trim_regs
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [15:0]           flash_trim,
    output logic                       flash_req,
    input  wire logic                  flash_valid,
    input  wire logic                  pll_lock_set,
    input  wire logic                  osc_up_set,
    output trim_pkg::temp_trim_type    temp_trim,
    output logic [4:0]                 thresh_raise,
    output trim_pkg::osc_trim_type     osc_trim,
    output logic                       clock_cfg_protect,
    output logic                       pll_select,
    output logic                       pll_lock_flag,
    output logic                       osc_up_flag
);
    import trim_pkg::*;

    logic [7:0]     temp_sense_trim_r;
    logic [15:0]    ref_osc_trim_r;
    load_state_type ld_state_r;
    logic [11:0]    awaddr_r;
    logic [31:0]    wdata_r;
    logic [3:0]     wstrb_r;
    logic           aw_have_r;
    logic           w_have_r;
    logic           wr_go;
    logic           osc_wr;
    logic           lock_s1_r;
    logic           lock_s2_r;
    logic           up_s1_r;
    logic           up_s2_r;
    logic [4:0]     raise_w;

    function automatic logic is_osc(input logic [11:0] a);
        is_osc = (a == `REF_OSC_TRIM_ADDR);
    endfunction

    // write channel: address and data taken in either order, response follows both
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    assign osc_wr = wr_go && is_osc(awaddr_r) && !clock_cfg_protect && (ld_state_r == LD_DONE);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_have_r     <= 1'b0;
            awaddr_r      <= 12'h000;
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_r     <= 1'b1;
            awaddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (wr_go)
        begin
            aw_have_r     <= 1'b0;
        end
        else if (!aw_have_r && !s_axi_bvalid)
        begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            w_have_r     <= 1'b0;
            wdata_r      <= 32'h0000_0000;
            wstrb_r      <= 4'h0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_r     <= 1'b1;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (wr_go)
        begin
            w_have_r     <= 1'b0;
        end
        else if (!w_have_r && !s_axi_bvalid)
        begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (is_osc(awaddr_r) || awaddr_r == `TEMP_SENSE_TRIM_ADDR ||
                             awaddr_r == `CLOCK_PROTECT_WADDR ||
                             awaddr_r == `PLL_CTRL_ADDR) ? 2'h0 : 2'h2;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // flash load after reset release; oscillator trim writes made before it lands are dropped, not held
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ld_state_r <= LD_IDLE;
            flash_req  <= 1'b0;
        end
        else
        begin
            unique case (ld_state_r)
                LD_IDLE:
                begin
                    ld_state_r <= LD_REQ;
                    flash_req  <= 1'b1; // R3
                end
                LD_REQ:
                begin
                    if (flash_valid)
                    begin
                        ld_state_r <= LD_DONE;
                        flash_req  <= 1'b0;
                    end
                end
                LD_DONE:
                begin
                    flash_req  <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ref_osc_trim_r <= `REF_OSC_RESET;
        end
        else if (ld_state_r == LD_REQ && flash_valid)
        begin
            ref_osc_trim_r <= flash_trim & `REF_OSC_MASK; // R3 R9
        end
        else if (osc_wr) // R4
        begin
            if (wstrb_r[0])
            begin
                ref_osc_trim_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1])
            begin
                ref_osc_trim_r[15:8] <= wdata_r[15:8] & 8'hFB; // R9
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            temp_sense_trim_r <= `TEMP_SENSE_RESET;
        end
        else if (wr_go && awaddr_r == `TEMP_SENSE_TRIM_ADDR && wstrb_r[0])
        begin
            temp_sense_trim_r <= wdata_r[7:0] & `TEMP_SENSE_MASK; // R9
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clock_cfg_protect <= `PROTECT_RESET;
            pll_select        <= 1'b0;
        end
        else if (wr_go && wstrb_r[0])
        begin
            if (awaddr_r == `CLOCK_PROTECT_WADDR)
            begin
                clock_cfg_protect <= (wdata_r[7:0] != `PROTECT_UNLOCK_KEY); // R8
            end
            if (awaddr_r == `PLL_CTRL_ADDR && !clock_cfg_protect)
            begin
                pll_select <= wdata_r[0];
            end
        end
    end

    // status inputs come from the analog side, so synchronise first
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
            up_s1_r   <= 1'b0;
            up_s2_r   <= 1'b0;
        end
        else
        begin
            lock_s1_r <= pll_lock_set;
            lock_s2_r <= lock_s1_r;
            up_s1_r   <= osc_up_set;
            up_s2_r   <= up_s1_r;
        end
    end

    // the clear wins here: a retrim invalidates whatever lock was reported
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pll_lock_flag <= 1'b0;
            osc_up_flag   <= 1'b0;
        end
        else if (osc_wr && pll_select)
        begin
            pll_lock_flag <= 1'b0; // R5
            osc_up_flag   <= 1'b0; // R5
        end
        else
        begin
            pll_lock_flag <= lock_s2_r;
            osc_up_flag   <= up_s2_r;
        end
    end

    thresh_weight u_weight
    (
        .en          (temp_sense_trim_r[`TEMP_OFFSET_EN_BIT]),
        .trim        (temp_sense_trim_r[3:0]),
        .raise_steps (raise_w)
    );

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            temp_trim    <= '0;
            thresh_raise <= 5'h00;
            osc_trim     <= '0;
        end
        else
        begin
            temp_trim.offset_en   <= temp_sense_trim_r[`TEMP_OFFSET_EN_BIT]; // R1
            temp_trim.thresh_trim <= temp_sense_trim_r[`TEMP_OFFSET_EN_BIT] ?
                                     temp_sense_trim_r[3:0] : 4'h0; // R1
            thresh_raise          <= raise_w; // R2
            osc_trim.tc_on        <= (ref_osc_trim_r[14:11] != 4'h0); // R6
            osc_trim.tc_positive  <= ref_osc_trim_r[`TEMPCO_MSB]; // R6
            osc_trim.tc_mag       <= ref_osc_trim_r[14:11]; // R6
            osc_trim.freq_trim    <= ref_osc_trim_r[`FREQ_MSB:`FREQ_LSB]; // R7
        end
    end

    // read channel, one cycle answer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            unique case (s_axi_araddr)
                `REF_OSC_TRIM_ADDR:    s_axi_rdata <= {16'h0000, ref_osc_trim_r}; // R4
                `TEMP_SENSE_TRIM_ADDR: s_axi_rdata <= {24'h000000, temp_sense_trim_r};
                `CLOCK_PROTECT_WADDR:  s_axi_rdata <= {31'h0, clock_cfg_protect};
                `PLL_CTRL_ADDR:        s_axi_rdata <= {31'h0, pll_select};
                `STATUS_ADDR:          s_axi_rdata <= {29'h0, ld_state_r == LD_DONE,
                                                       osc_up_flag, pll_lock_flag};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    property p_protect_blocks;
        @(posedge clk) disable iff (rst)
        (wr_go && is_osc(awaddr_r) && clock_cfg_protect && (ld_state_r == LD_DONE))
            |=> $stable(ref_osc_trim_r);
    endproperty
    a_protect_blocks: assert property (p_protect_blocks) else $error("protected write landed"); // R4

    property p_clear_flags;
        @(posedge clk) disable iff (rst)
        (osc_wr && pll_select) |=> (!pll_lock_flag && !osc_up_flag);
    endproperty
    a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared"); // R5

    property p_key;
        @(posedge clk) disable iff (rst)
        (wr_go && awaddr_r == `CLOCK_PROTECT_WADDR && wstrb_r[0])
            |=> (clock_cfg_protect == ($past(wdata_r[7:0]) != `PROTECT_UNLOCK_KEY));
    endproperty
    a_key: assert property (p_key) else $error("protect key wrong"); // R8

    property p_unimpl;
        @(posedge clk) disable iff (rst)
        (temp_sense_trim_r[6:4] == 3'h0) && (ref_osc_trim_r[10] == 1'b0);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set"); // R9

    property p_load;
        @(posedge clk) disable iff (rst)
        (ld_state_r == LD_REQ && flash_valid) |=> ref_osc_trim_r == ($past(flash_trim) & 16'hFBFF);
    endproperty
    a_load: assert property (p_load) else $error("flash trim not loaded"); // R3

    property p_offset_off;
        @(posedge clk) disable iff (rst)
        !temp_sense_trim_r[7] |=> (temp_trim.thresh_trim == 4'h0 && thresh_raise == 5'h00);
    endproperty
    a_offset_off: assert property (p_offset_off) else $error("trim not ignored"); // R1 R2

    property p_tc_off;
        @(posedge clk) disable iff (rst)
        (ref_osc_trim_r[14:11] == 4'h0) |=> !osc_trim.tc_on;
    endproperty
    a_tc_off: assert property (p_tc_off) else $error("tc not off"); // R6

    property p_freq;
        @(posedge clk) disable iff (rst)
        1'b1 |=> osc_trim.freq_trim == $past(ref_osc_trim_r[9:0]);
    endproperty
    a_freq: assert property (p_freq) else $error("freq trim mismatch"); // R7
endmodule
`default_nettype wire

// File: sim/oscillator_temp_trim_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "trim_map.svh"
module oscillator_temp_trim_regs_tb_top;
    import trim_pkg::*;
    localparam logic [11:0] A_OSC  = `REF_OSC_TRIM_ADDR;
    localparam logic [11:0] A_TMP  = `TEMP_SENSE_TRIM_ADDR;
    localparam logic [11:0] A_CFG  = `CLOCK_PROTECT_WADDR;
    localparam logic [11:0] A_STAT = `STATUS_ADDR;
    localparam logic [11:0] A_PLL  = `PLL_CTRL_ADDR;
    logic          clk;
    logic          rst;
    logic [11:0]   awaddr;
    logic [11:0]   araddr;
    logic          awvalid;
    logic          awready;
    logic          wvalid;
    logic          wready;
    logic          bvalid;
    logic          bready;
    logic          arvalid;
    logic          arready;
    logic          rvalid;
    logic          rready;
    logic [31:0]   wdata;
    logic [31:0]   rdata;
    logic [3:0]    wstrb;
    logic [1:0]    bresp;
    logic [1:0]    rresp;
    logic [15:0]   flash_trim;
    logic          flash_req;
    logic          flash_valid;
    logic          lock_in;
    logic          up_in;
    temp_trim_type temp_trim;
    osc_trim_type  osc_trim;
    logic [4:0]    thresh_raise;
    logic          cfg_lock;
    logic          pll_sel;
    logic          lock_flag;
    logic          up_flag;
    logic          watch;
    logic          seen_clear;
    logic [1:0]    rs;
    logic [7:0]    tv [7] = '{8'hFF, 8'h8A, 8'h0A, 8'h81, 8'h82, 8'h84, 8'h88};
    logic [15:0]   ov [5] = '{16'h0000, 16'h8000, 16'hF800, 16'h0BFF, 16'h7C01};
    int            fails;
    int            checked;

    osc_temp_trim_regs u_dut
    (
        .clk               (clk),
        .rst               (rst),
        .s_axi_awaddr      (awaddr),
        .s_axi_awvalid     (awvalid),
        .s_axi_awready     (awready),
        .s_axi_wdata       (wdata),
        .s_axi_wstrb       (wstrb),
        .s_axi_wvalid      (wvalid),
        .s_axi_wready      (wready),
        .s_axi_bresp       (bresp),
        .s_axi_bvalid      (bvalid),
        .s_axi_bready      (bready),
        .s_axi_araddr      (araddr),
        .s_axi_arvalid     (arvalid),
        .s_axi_arready     (arready),
        .s_axi_rdata       (rdata),
        .s_axi_rresp       (rresp),
        .s_axi_rvalid      (rvalid),
        .s_axi_rready      (rready),
        .flash_trim        (flash_trim),
        .flash_req         (flash_req),
        .flash_valid       (flash_valid),
        .pll_lock_set      (lock_in),
        .osc_up_set        (up_in),
        .temp_trim         (temp_trim),
        .thresh_raise      (thresh_raise),
        .osc_trim          (osc_trim),
        .clock_cfg_protect (cfg_lock),
        .pll_select        (pll_sel),
        .pll_lock_flag     (lock_flag),
        .osc_up_flag       (up_flag)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // the clear lasts one cycle only, so it is latched while watching
    always @(posedge clk)
        seen_clear <= watch && (seen_clear || (lock_flag === 1'b0 && up_flag === 1'b0));

    function automatic osc_trim_type exp_osc(input logic [15:0] v);
        exp_osc = {|v[14:11], v[15], v[14:11], v[9:0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            n++;
        end
        while (bvalid !== 1'b1 && n < 50);
        resp = bresp;
        bready <= 1'b0;
        check(bvalid, 1'b1);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            n++;
        end
        while (rvalid !== 1'b1 && n < 50);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        check(rvalid, 1'b1);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check(d, ed);
        check(r, er);
    endtask

    task automatic test_done;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // whole sequence needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        test_done;
    end

    initial
    begin
        rst = 1'b1;
        {awaddr, araddr, wdata, flash_trim} = '0;
        {awvalid, wvalid, bready, arvalid, rready, flash_valid, lock_in, up_in} = '0;
        wstrb = 4'hF;
        watch = 1'b0;
        fails = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // a write before the load lands must not survive it
        wr(A_OSC, 32'h1234, rs);
        rc(A_OSC, 32'h0, 2'h0);
        for (int i = 0; i < 20 && flash_req !== 1'b1; i++) @(posedge clk);
        check(flash_req, 1'b1);
        flash_trim  <= 16'hA7FF;
        flash_valid <= 1'b1;
        for (int i = 0; i < 20 && flash_req === 1'b1; i++) @(posedge clk);
        flash_valid <= 1'b0;
        rc(A_OSC, 32'h0000A3FF, 2'h0);
        check(osc_trim, exp_osc(16'hA7FF));
        foreach (tv[i])
        begin
            wr(A_TMP, {24'h0, tv[i]}, rs);
            rc(A_TMP, {24'h0, tv[i] & 8'h8F}, 2'h0);
            check(temp_trim, {tv[i][7], tv[i][7] ? tv[i][3:0] : 4'h0});
            check(thresh_raise, tv[i][7] ? {1'b0, tv[i][3:0]} : 5'h0);
        end
        foreach (ov[i])
        begin
            wr(A_OSC, {16'h0, ov[i]}, rs);
            rc(A_OSC, {16'h0, ov[i] & 16'hFBFF}, 2'h0);
            check(osc_trim, exp_osc(ov[i]));
        end
        // high lane alone must leave the low byte untouched
        wstrb <= 4'h2;
        wr(A_OSC, 32'h0000FF3C, rs);
        wstrb <= 4'hF;
        rc(A_OSC, 32'h0000FB01, 2'h0);
        check(osc_trim, exp_osc(16'hFB01));
        // near-miss key must lock, not unlock
        wr(A_CFG, 32'h27, rs);
        repeat (2) @(posedge clk);
        check(cfg_lock, 1'b1);
        rc(A_CFG, 32'h1, 2'h0);
        wr(A_OSC, 32'h5555, rs);
        check(rs, 2'h0);
        rc(A_OSC, 32'h0000FB01, 2'h0);
        wr(A_PLL, 32'h1, rs);
        repeat (2) @(posedge clk);
        check(pll_sel, 1'b0);
        wr(A_CFG, 32'h26, rs);
        repeat (2) @(posedge clk);
        check(cfg_lock, 1'b0);
        rc(A_CFG, 32'h0, 2'h0);
        wr(A_PLL, 32'h1, rs);
        repeat (2) @(posedge clk);
        check(pll_sel, 1'b1);
        rc(A_PLL, 32'h1, 2'h0);
        lock_in <= 1'b1;
        up_in   <= 1'b1;
        repeat (6) @(posedge clk);
        check({lock_flag, up_flag}, 2'b11);
        rc(A_STAT, 32'h7, 2'h0);
        watch <= 1'b1;
        wr(A_OSC, 32'h0123, rs);
        repeat (6) @(posedge clk);
        check(seen_clear, 1'b1);
        check(osc_trim, exp_osc(16'h0123));
        check({lock_flag, up_flag}, 2'b11);
        watch <= 1'b0;
        wr(A_PLL, 32'h0, rs);
        repeat (2) @(posedge clk);
        watch <= 1'b1;
        wr(A_OSC, 32'h0456, rs);
        repeat (6) @(posedge clk);
        check(seen_clear, 1'b0);
        watch <= 1'b0;
        rc(12'h100, 32'h0, 2'h2);
        wr(12'h100, 32'hFFFF, rs);
        check(rs, 2'h2);
        test_done;
    end
endmodule
`default_nettype wire
